// [dv/fpd_decoder_bench.sv]
// Self-checking bench for the coprocessor opcode decoder.
`timescale 1ns/100ps
module fpd_decoder_bench
	import fpd_pkg::*;
;
	logic       sys_clk = 1'b0;
	logic       nrst = 1'b0;
	logic       slow = 1'b0;
	logic       match = 1'b1;
	logic       ce = 1'b1;
	logic       exec_done, exec_match, host_ready, func_ready, cmd_valid, reply_valid, busy;
	logic [7:0] reply_data, last_rep;
	fpd_byte_s  host_in = '0;
	fpd_byte_s  func_in;
	fpd_call_s  call_out;
	fpd_cmd_s   cmd_out, last_cmd;
	int         mismatches = 0;
	int         num_checks = 0;
	int         ncmd = 0;
	int         nrep = 0;

	always #12.5 sys_clk = ~sys_clk;

	fpd_decoder uut (.sys_clk, .nrst, .ce(ce), .host_in, .host_ready, .func_in, .func_ready, .call_out,
		.cmd_out, .cmd_valid, .exec_done, .exec_match, .reply_valid, .reply_data, .busy);
	fpd_exec_model far (.sys_clk, .nrst, .slow, .match, .cmd_valid, .call_out, .func_ready, .func_in,
		.exec_done, .exec_match);

	// Keep the newest command and count every answer
	always @(posedge sys_clk) begin
		if (cmd_valid === 1'b1) begin
			last_cmd <= cmd_out;
			ncmd <= ncmd + 1;
		end
		if (reply_valid === 1'b1) begin
			nrep     <= nrep + 1;
			last_rep <= reply_data;
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		num_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic end_sim;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : end_sim

	// Hold each byte until an edge sees host_ready high
	task automatic send(input logic [7:0] b);
		int n;
		n = 0;
		host_in <= {1'b1, b, 1'b0};
		do begin
			@(posedge sys_clk);
			n++;
		end while (host_ready !== 1'b1 && n < 300);
		if (n >= 300) begin
			mismatches++;
			end_sim();
		end
	endtask : send

	// Send a byte string, then wait for idle and count commands
	task automatic run(input logic [7:0] q[$], input int dn);
		int n0, n;
		n0 = ncmd;
		n = 0;
		foreach (q[i]) send(q[i]);
		host_in <= {1'b0, ~q[q.size() - 1], 1'b0};
		@(posedge sys_clk);
		do begin
			@(posedge sys_clk);
			n++;
		end while (!(busy === 1'b0 && host_ready === 1'b1) && n < 300);
		if (n >= 300) begin
			mismatches++;
			end_sim();
		end
		chk(ncmd - n0, dn, "command count");
	endtask : run

	task automatic t_load(input logic [3:0] hi, input logic [3:0] r);
		run('{{hi, r}, 8'h12, 8'h34, 8'h56, 8'h7f}, 1);
		chk(last_cmd.op, FPD_OP_WRITE_REG, "load op");
		chk(last_cmd.idx, r, "load index");
		chk(last_cmd.arg, 32'h1234567f, "load value");
	endtask : t_load

	task automatic t_arith;
		fpd_op_e ops[9] = '{FPD_OP_COPY, FPD_OP_FSUM, FPD_OP_FDIFF, FPD_OP_FPROD, FPD_OP_FQUOT,
			FPD_OP_ISUM, FPD_OP_IDIFF, FPD_OP_IPROD, FPD_OP_IQUOT};
		for (int h = 5; h < 14; h++) begin
			run('{{h[3:0], h[3:0]}}, 1);
			chk(last_cmd.op, ops[h - 5], "binary op");
			chk(last_cmd.b_ptr, h[3:0], "b pointer");
			chk(last_cmd.a_ptr, 4'h5, "a pointer kept");
		end
	endtask : t_arith

	task automatic t_unary;
		slow <= 1'b1;
		for (int lo = 0; lo < 16; lo++) begin
			run('{{4'he, lo[3:0]}}, 1);
			chk(last_cmd.op, FPD_OP_UNARY, "unary op");
			chk(last_cmd.aux, lo[3:0], "unary selector");
		end
		slow <= 1'b0;
	endtask : t_unary

	// Field sel: 0 idx, 1 arg, 2 aux, 3 a pointer
	task automatic t_one(input logic [7:0] q[$], input int dn, input fpd_op_e op, input int sel,
		input logic [31:0] exp);
		run(q, dn);
		chk(last_cmd.op, op, "op");
		if (sel == 0) chk(last_cmd.idx, exp, "idx");
		else if (sel == 1) chk(last_cmd.arg, exp, "arg");
		else if (sel == 2) chk(last_cmd.aux, exp, "aux");
		else chk(last_cmd.a_ptr, exp, "a pointer");
	endtask : t_one

	// stored function with and without a match
	task automatic t_func(input logic m, input int dn, input fpd_op_e op);
		match <= m;
		run('{8'hfe, 8'h07}, dn);
		chk(last_cmd.op, op, "function tail op");
	endtask : t_func

	initial begin
		repeat (8) @(posedge sys_clk);
		nrst <= 1'b1;
		@(posedge sys_clk);
		chk({busy, cmd_valid, reply_valid, call_out.valid}, 4'h0, "idle after reset");
		// Enable low freezes the decoder, so an offered sync byte is never taken
		ce <= 1'b0;
		host_in <= {1'b1, 8'hf0, 1'b0};
		repeat (3) @(posedge sys_clk);
		ce <= 1'b1;
		chk(nrep, 0, "frozen sync");
		t_load(FPD_HI_LOAD_B, 4'ha);
		t_load(FPD_HI_LOAD_A, 4'h5);
		t_arith();
		t_unary();
		t_one('{8'hf1}, 1, FPD_OP_TO_FLOAT, 0, 0);
		t_one('{8'hf2}, 1, FPD_OP_TO_LONG, 0, 0);
		t_one('{8'hf4, 8'hff}, 1, FPD_OP_LOAD_INT, 1, 32'hffffffff);
		t_one('{8'hf5, 8'hff}, 1, FPD_OP_LOAD_INT, 1, 32'h000000ff);
		t_one('{8'hf6, 8'h80, 8'h01}, 1, FPD_OP_LOAD_INT, 1, 32'hffff8001);
		t_one('{8'hf7, 8'h80, 8'h01}, 1, FPD_OP_LOAD_INT, 1, 32'h00008001);
		t_one('{8'hfa, 8'h3c}, 1, FPD_OP_REAL_TEXT, 2, 8'h3c);
		t_one('{8'hfc, 8'h05}, 1, FPD_OP_INT_TEXT, 2, 8'h05);
		t_one('{8'hf9, 8'h31, 8'h2e, 8'h35, 8'h00}, 4, FPD_OP_TEXT_REAL, 0, 0);
		t_one('{8'hfb, 8'h37, 8'h00}, 2, FPD_OP_TEXT_INT, 0, 0);
		t_one('{8'hf8}, 1, FPD_OP_TEXT_FETCH, 3, 4'h5);
		t_one('{8'hfd}, 1, FPD_OP_STATUS, 3, 4'h5);
		t_one('{8'h4b}, 1, FPD_OP_READ_REG, 0, 4'hb);
		t_one('{8'h07, 8'h69}, 1, FPD_OP_FSUM, 3, 4'h7);
		t_one('{8'hfe, 8'h94}, 1, FPD_OP_EXT_OTHER, 2, 8'h94);
		run('{8'hff, 8'hf0, 8'h1c}, 0);
		chk(nrep, 1, "sync replies");
		chk(last_rep, FPD_SYNC_BYTE, "sync byte");
		t_func(1'b1, 3, FPD_OP_FSUM);
		t_func(1'b0, 2, FPD_OP_COND);
		chk(last_cmd.aux, 8'h0f, "condition byte");
		run('{8'hfe, 8'h80, 8'h0f}, 0);
		end_sim();
	end
endmodule : fpd_decoder_bench

// [dv/fpd_decoder_properties.sv]
// Port-level checker for the coprocessor opcode decoder.
`timescale 1ns/100ps
module fpd_decoder_properties
	import fpd_pkg::*;
(
	input wire logic       sys_clk,
	input wire logic       nrst,
	input wire logic       ce,
	input wire fpd_byte_s  host_in,
	input wire logic       host_ready,
	input wire logic       func_ready,
	input wire fpd_call_s  call_out,
	input wire fpd_cmd_s   cmd_out,
	input wire logic       cmd_valid,
	input wire logic       reply_valid,
	input wire logic [7:0] reply_data,
	input wire logic       busy
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	// Opcode byte taken from the host while idle
	wire logic take_h = ce && host_in.valid && host_ready && !busy;

	chk_sync_value: // sync value
		assert property (reply_valid |-> reply_data == FPD_SYNC_BYTE) else $error("sync byte wrong");
	chk_sync_answer: // sync answer
		assert property (take_h && host_in.data == 8'hf0 |=> reply_valid) else $error("no sync reply");
	chk_nop_quiet: // nop silent
		assert property (take_h && host_in.data == 8'hff |=> !cmd_valid && !reply_valid && !busy)
			else $error("nop gave output");
	chk_cmd_busy: // busy on command
		assert property (cmd_valid |-> busy && !host_ready) else $error("command while not busy");
	chk_call_num: // function number
		assert property (call_out.valid |-> call_out.num == $past(host_in.data[5:0])) else $error("call number");
	chk_call_ready: // function starts
		assert property (call_out.valid |=> func_ready && busy) else $error("function not started");
	chk_func_busy: // busy in function
		assert property (func_ready |-> busy && !host_ready) else $error("host open in function");
	chk_load_lsb: // last load byte
		assert property (cmd_valid && cmd_out.op == FPD_OP_WRITE_REG && !$past(func_ready)
			|-> cmd_out.arg[7:0] == $past(host_in.data)) else $error("load byte order");
	chk_arith_ptr: // B select
		assert property (take_h && host_in.data[7:4] == FPD_HI_FSUM |=> cmd_valid && cmd_out.op == FPD_OP_FSUM
			&& cmd_out.b_ptr == $past(host_in.data[3:0])) else $error("sum command");
	cover property (call_out.valid);
	cover property (reply_valid);
	cover property (cmd_valid && cmd_out.op == FPD_OP_COND);
endmodule : fpd_decoder_properties

bind fpd_decoder fpd_decoder_properties u_props (.sys_clk, .nrst, .ce, .host_in, .host_ready, .func_ready,
	.call_out, .cmd_out, .cmd_valid, .reply_valid, .reply_data, .busy);

// [dv/fpd_exec_model.sv]
// Behavioural execution unit and stored-function memory facing the decoder.
`timescale 1ns/100ps
module fpd_exec_model
	import fpd_pkg::*;
(
	input  wire logic      sys_clk,
	input  wire logic      nrst,
	input  wire logic      slow,
	input  wire logic      match,
	input  wire logic      cmd_valid,
	input  wire fpd_call_s call_out,
	input  wire logic      func_ready,
	output fpd_byte_s      func_in,
	output logic           exec_done,
	output logic           exec_match
);
	// One function: pointer op, sum, condition, sum, nop as last byte
	localparam logic [7:0] FN_BODY [7] = '{8'h12, 8'h65, 8'hfe, 8'h80, 8'h0f, 8'h63, 8'hff};
	logic [3:0] wait_reg;
	logic [2:0] ptr_reg;
	logic       run_reg;

	// Finish each command with exec_done two or seven cycles after cmd_valid
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			wait_reg  <= 4'h0;
			exec_done <= 1'b0;
		end else begin
			exec_done <= (wait_reg == 4'h1);
			if (cmd_valid) wait_reg <= slow ? 4'h6 : 4'h1;
			else if (wait_reg != 4'h0) wait_reg <= wait_reg - 4'h1;
		end
	end
	assign exec_match = match;

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			run_reg <= 1'b0;
			ptr_reg <= 3'h0;
		end else if (call_out.valid) begin
			run_reg <= 1'b1;
			ptr_reg <= 3'h0;
		end else if (run_reg && func_ready) begin
			run_reg <= (ptr_reg != 3'h6);
			ptr_reg <= ptr_reg + 3'h1;
		end
	end
	// Idle data is zero, never a stale copy of a function byte
	assign func_in = {run_reg, run_reg ? FN_BODY[ptr_reg] : 8'h00, run_reg && ptr_reg == 3'h6};
endmodule : fpd_exec_model

// [hdl/fpd_arg_shift.sv]
// Argument byte collector: shifts bytes in, most significant first.
`timescale 1ns/100ps
module fpd_arg_shift
	import fpd_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        nrst,
	input  wire logic        ce,
	input  wire logic        start,
	input  wire logic [2:0]  count,
	input  wire logic        shift,
	input  wire logic [7:0]  din,
	output logic      [31:0] word,
	output logic             last
);

	logic [23:0] hold_reg;
	logic [23:0] hold_next;
	logic [2:0]  left_reg;
	logic [2:0]  left_next;

	// Word seen with the byte now arriving, so completion costs no cycle
	assign word = {hold_reg, din};
	assign last = (left_reg == 3'h1);

	// Next values
	always_comb begin
		hold_next = hold_reg;
		left_next = left_reg;
		if (start) begin
			hold_next = 24'h00_0000;
			left_next = count;
		end else if (shift) begin
			hold_next = {hold_reg[15:0], din};
			left_next = left_reg - 3'h1;
		end
	end

	// Registers
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			hold_reg <= 24'h00_0000;
			left_reg <= 3'h0;
		end else if (ce) begin
			hold_reg <= hold_next;
			left_reg <= left_next;
		end
	end

endmodule : fpd_arg_shift

// [hdl/fpd_decoder.sv]
// Opcode stream decoder for the floating point / long integer coprocessor.
// What this block does
// - 2x selects register n as A and loads following 32-bit float into it.
// - 3x selects register n as B and loads following 32-bit float into it.
// - 5x selects n as B and copies B into A, any type.
// - 6x..9x select n as B then float add, subtract, multiply, divide into A.
// - Ax..Cx select n as B then long add, subtract, multiply into A.
// - Dx selects n as B, signed long divide, quotient A, remainder register 0.
// - E0..EF apply a unary float function to A in place.
// - E8, E9, EA give floor, ceiling and nearest integer of A, as float.
// - F1 copies A to register 0 long-to-float; F2 float-to-long.
// - F4..F7 take signed/unsigned byte or word into register 0, to float.
// - FD returns one float status byte for register A.
// - F8 returns the text buffer as ASCII ending in a zero byte.
// - F9 takes zero-ended text, parses float into register 0.
// - FB takes zero-ended text, parses long into register 0.
// - FA takes a format byte, converts float to text in the buffer.
// - FC takes a format byte, converts long to text in the buffer.
// - FE is a prefix joining the next byte into an extended opcode.
// - FE00..FE3F outside a function call stored function numbered by second byte's low six bits.
// - FE80..FE84 take a condition byte; function continues only on a match.
// - Conditionals, table, polynomial only inside functions; busy holds until function ends.
`timescale 1ns/100ps
module fpd_decoder
	import fpd_pkg::*;
(
	input  wire logic      sys_clk,
	input  wire logic      nrst,
	input  wire logic      ce,
	input  wire fpd_byte_s host_in,
	output logic           host_ready,
	input  wire fpd_byte_s func_in,
	output logic           func_ready,
	output fpd_call_s      call_out,
	output fpd_cmd_s       cmd_out,
	output logic           cmd_valid,
	input  wire logic      exec_done,
	input  wire logic      exec_match,
	output logic           reply_valid,
	output logic [7:0]     reply_data,
	output logic           busy
);

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	fpd_state_e state_reg,      state_next;
	logic [3:0] a_ptr_reg,      a_ptr_next;
	logic [3:0] b_ptr_reg,      b_ptr_next;
	fpd_op_e    pend_op_reg,    pend_op_next;
	logic [3:0] pend_code_reg,  pend_code_next;
	logic       text_reg,       text_next;
	logic       in_func_reg,    in_func_next;
	logic       end_pend_reg,   end_pend_next;
	fpd_cmd_s   cmd_reg,        cmd_next;
	logic       cmd_valid_reg,  cmd_valid_next;
	fpd_call_s  call_reg,       call_next;
	logic       reply_vld_reg,  reply_vld_next;
	logic [7:0] reply_dat_reg,  reply_dat_next;
	logic       host_rdy_reg,   host_rdy_next;
	logic       func_rdy_reg,   func_rdy_next;
	logic       busy_reg,       busy_next;

	// Decode scratch
	fpd_byte_s   src;
	logic        take;
	logic [3:0]  hi;
	logic [3:0]  lo;
	logic        issue;
	fpd_op_e     iss_op;
	logic [3:0]  iss_idx;
	logic [7:0]  iss_aux;
	logic [31:0] iss_arg;
	logic        arg_start;
	logic [2:0]  arg_count;
	logic        arg_shift;
	logic [31:0] arg_word;
	logic        arg_last;
	logic        accept;

	// ------------------------------------------------------------------
	// Byte source
	// ------------------------------------------------------------------
	// Stored function bytes replace the host stream while a call runs
	assign src  = in_func_reg ? func_in : host_in;
	assign take = src.valid && (in_func_reg ? func_rdy_reg : host_rdy_reg);
	assign hi   = src.data[7:4];
	assign lo   = src.data[3:0];

	// Argument collector
	fpd_arg_shift u_arg (
		.sys_clk (sys_clk),
		.nrst    (nrst),
		.ce      (ce),
		.start   (arg_start),
		.count   (arg_count),
		.shift   (arg_shift),
		.din     (src.data),
		.word    (arg_word),
		.last    (arg_last)
	);

	// ------------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------------
	// Next-state logic for the whole decoder
	always_comb begin
		state_next     = state_reg;
		a_ptr_next     = a_ptr_reg;
		b_ptr_next     = b_ptr_reg;
		pend_op_next   = pend_op_reg;
		pend_code_next = pend_code_reg;
		text_next      = text_reg;
		in_func_next   = in_func_reg;
		end_pend_next  = end_pend_reg;
		cmd_next       = cmd_reg;
		cmd_valid_next = 1'b0;
		call_next      = call_reg;
		call_next.valid = 1'b0;
		reply_vld_next = 1'b0;
		reply_dat_next = reply_dat_reg;
		issue          = 1'b0;
		iss_op         = FPD_OP_NOP;
		iss_idx        = FPD_REG_ZERO;
		iss_aux        = 8'h00;
		iss_arg        = 32'h0000_0000;
		arg_start      = 1'b0;
		arg_count      = FPD_ARGS_BYTE;
		arg_shift      = 1'b0;

		if (take && in_func_reg && src.last) begin
			end_pend_next = 1'b1;
		end

		case (state_reg)
			FPD_S_IDLE: begin
				if (take) begin
					case (hi)
						FPD_HI_PICK_A: begin
							a_ptr_next = lo;
						end
						FPD_HI_PICK_B: begin
							b_ptr_next = lo;
						end
						FPD_HI_LOAD_A: begin
							a_ptr_next     = lo;
							pend_op_next   = FPD_OP_WRITE_REG;
							pend_code_next = lo;
							arg_start      = 1'b1;
							arg_count      = FPD_ARGS_REAL;
							state_next     = FPD_S_ARG;
						end
						FPD_HI_LOAD_B: begin
							b_ptr_next     = lo;
							pend_op_next   = FPD_OP_WRITE_REG;
							pend_code_next = lo;
							arg_start      = 1'b1;
							arg_count      = FPD_ARGS_REAL;
							state_next     = FPD_S_ARG;
						end
						FPD_HI_READBACK: begin
							issue   = 1'b1;
							iss_op  = FPD_OP_READ_REG;
							iss_idx = lo;
						end
						FPD_HI_UNARY: begin
							issue   = 1'b1;
							iss_op  = FPD_OP_UNARY;
							iss_aux = {4'h0, lo};
						end
						FPD_HI_MISC: begin
							case (lo)
								FPD_LO_SYNC: begin
									reply_vld_next = 1'b1;
									reply_dat_next = FPD_SYNC_BYTE;
								end
								FPD_LO_TO_FLOAT: begin
									issue  = 1'b1;
									iss_op = FPD_OP_TO_FLOAT;
								end
								FPD_LO_TO_LONG: begin
									issue  = 1'b1;
									iss_op = FPD_OP_TO_LONG;
								end
								FPD_LO_FLOAT_COMPARE_OP: begin
									issue  = 1'b1;
									iss_op = FPD_OP_FLOAT_COMPARE_OP;
								end
								FPD_LO_SBYTE, FPD_LO_UBYTE, FPD_LO_SWORD, FPD_LO_UWORD: begin
									pend_op_next   = FPD_OP_LOAD_INT;
									pend_code_next = lo;
									arg_start      = 1'b1;
									arg_count      = lo[1] ? FPD_ARGS_WORD : FPD_ARGS_BYTE;
									state_next     = FPD_S_ARG;
								end
								FPD_LO_TEXT_FETCH: begin
									issue  = 1'b1;
									iss_op = FPD_OP_TEXT_FETCH;
								end
								FPD_LO_TEXT_REAL: begin
									pend_op_next = FPD_OP_TEXT_REAL;
									state_next   = FPD_S_TEXT;
								end
								FPD_LO_REAL_TEXT: begin
									pend_op_next = FPD_OP_REAL_TEXT;
									arg_start    = 1'b1;
									state_next   = FPD_S_ARG;
								end
								FPD_LO_TEXT_INT: begin
									pend_op_next = FPD_OP_TEXT_INT;
									state_next   = FPD_S_TEXT;
								end
								FPD_LO_INT_TEXT: begin
									pend_op_next = FPD_OP_INT_TEXT;
									arg_start    = 1'b1;
									state_next   = FPD_S_ARG;
								end
								FPD_LO_STATUS: begin
									issue  = 1'b1;
									iss_op = FPD_OP_STATUS;
								end
								FPD_LO_PREFIX: begin
									state_next = FPD_S_PREFIX;
								end
								default: begin
									state_next = FPD_S_IDLE;
								end
							endcase
						end
						// pick B, then operate on A
						default: begin
							b_ptr_next = lo;
							issue      = 1'b1;
							case (hi)
								FPD_HI_COPY:  iss_op = FPD_OP_COPY;
								FPD_HI_FSUM:  iss_op = FPD_OP_FSUM;
								FPD_HI_FDIFF: iss_op = FPD_OP_FDIFF;
								FPD_HI_FPROD: iss_op = FPD_OP_FPROD;
								FPD_HI_FQUOT: iss_op = FPD_OP_FQUOT;
								FPD_HI_ISUM:  iss_op = FPD_OP_ISUM;
								FPD_HI_IDIFF: iss_op = FPD_OP_IDIFF;
								FPD_HI_IPROD: iss_op = FPD_OP_IPROD;
								default:      iss_op = FPD_OP_IQUOT;
							endcase
						end
					endcase
				end
			end
			FPD_S_PREFIX: begin
				if (take) begin
					state_next = FPD_S_IDLE;
					if (src.data[7:6] == FPD_EXT_CALL_TOP) begin
						if (!in_func_reg) begin
							call_next.valid = 1'b1;
							call_next.num   = src.data[5:0];
							in_func_next    = 1'b1;
							end_pend_next   = 1'b0;
						end
					end else if (src.data >= FPD_EXT_COND_LO && src.data <= FPD_EXT_COND_HI) begin
						if (in_func_reg) begin
							pend_op_next   = FPD_OP_COND;
							pend_code_next = src.data[3:0];
							arg_start      = 1'b1;
							state_next     = FPD_S_ARG;
						end
					// table and polynomial refused from host
					end else if (src.data == FPD_EXT_TABLE || src.data == FPD_EXT_POLY) begin
						issue   = in_func_reg;
						iss_op  = FPD_OP_EXT_OTHER;
						iss_aux = src.data;
					end else begin
						issue   = 1'b1;
						iss_op  = FPD_OP_EXT_OTHER;
						iss_aux = src.data;
					end
				end
			end
			FPD_S_ARG: begin
				if (take) begin
					arg_shift = 1'b1;
					if (arg_last) begin
						issue  = 1'b1;
						iss_op = pend_op_reg;
						case (pend_op_reg)
							FPD_OP_WRITE_REG: begin
								iss_idx = pend_code_reg;
								iss_arg = arg_word;
							end
							FPD_OP_LOAD_INT: begin
								case (pend_code_reg)
									FPD_LO_SBYTE: iss_arg = {{24{arg_word[7]}}, arg_word[7:0]};
									FPD_LO_UBYTE: iss_arg = {24'h00_0000, arg_word[7:0]};
									FPD_LO_SWORD: iss_arg = {{16{arg_word[15]}}, arg_word[15:0]};
									default:      iss_arg = {16'h0000, arg_word[15:0]};
								endcase
							end
							FPD_OP_COND: begin
								iss_aux = arg_word[7:0];
								iss_arg = {28'h000_0000, pend_code_reg};
							end
							default: begin
								iss_aux = arg_word[7:0];
							end
						endcase
					end
				end
			end
			FPD_S_TEXT: begin
				if (take) begin
					issue = 1'b1;
					if (src.data == FPD_STR_END) begin
						iss_op    = pend_op_reg;
						text_next = 1'b0;
					end else begin
						iss_op    = FPD_OP_TEXT_CHAR;
						iss_aux   = src.data;
						text_next = 1'b1;
					end
				end
			end
			FPD_S_EXEC: begin
				if (exec_done) begin
					// mismatch drops the rest of the function
					if (cmd_reg.op == FPD_OP_COND && !exec_match && !end_pend_reg) begin
						state_next = FPD_S_SKIP;
					end else begin
						state_next = text_reg ? FPD_S_TEXT : FPD_S_IDLE;
					end
				end
			end
			FPD_S_SKIP: begin
				if (take && src.last) begin
					state_next = FPD_S_IDLE;
				end
			end
			default: begin
				state_next = FPD_S_IDLE;
			end
		endcase

		// Command built with the pointers this opcode just picked
		if (issue) begin
			cmd_next.op    = iss_op;
			cmd_next.a_ptr = a_ptr_next;
			cmd_next.b_ptr = b_ptr_next;
			cmd_next.idx   = iss_idx;
			cmd_next.aux   = iss_aux;
			cmd_next.arg   = iss_arg;
			cmd_valid_next = 1'b1;
			state_next     = FPD_S_EXEC;
		end

		// function ends only once its last opcode is done
		if (state_next == FPD_S_IDLE && end_pend_next) begin
			in_func_next  = 1'b0;
			end_pend_next = 1'b0;
		end

		// Ready only in byte-taking states, never while a command launches
		accept = (state_next != FPD_S_EXEC) && !cmd_valid_next && !call_next.valid;
		host_rdy_next = accept && !in_func_next;
		func_rdy_next = accept && in_func_next && !end_pend_next;
		busy_next = in_func_next || (state_next != FPD_S_IDLE);
	end

	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			state_reg     <= FPD_S_IDLE;
			a_ptr_reg     <= FPD_PTR_RST;
			b_ptr_reg     <= FPD_PTR_RST;
			pend_op_reg   <= FPD_OP_NOP;
			pend_code_reg <= 4'h0;
			text_reg      <= 1'b0;
			in_func_reg   <= 1'b0;
			end_pend_reg  <= 1'b0;
			cmd_reg       <= '0;
			cmd_valid_reg <= 1'b0;
			call_reg      <= '0;
			reply_vld_reg <= 1'b0;
			reply_dat_reg <= 8'h00;
			host_rdy_reg  <= 1'b0;
			func_rdy_reg  <= 1'b0;
			busy_reg      <= 1'b0;
		end else if (ce) begin
			state_reg     <= state_next;
			a_ptr_reg     <= a_ptr_next;
			b_ptr_reg     <= b_ptr_next;
			pend_op_reg   <= pend_op_next;
			pend_code_reg <= pend_code_next;
			text_reg      <= text_next;
			in_func_reg   <= in_func_next;
			end_pend_reg  <= end_pend_next;
			cmd_reg       <= cmd_next;
			cmd_valid_reg <= cmd_valid_next;
			call_reg      <= call_next;
			reply_vld_reg <= reply_vld_next;
			reply_dat_reg <= reply_dat_next;
			host_rdy_reg  <= host_rdy_next;
			func_rdy_reg  <= func_rdy_next;
			busy_reg      <= busy_next;
		end
	end

	// Outputs straight from flops
	assign host_ready  = host_rdy_reg;
	assign func_ready  = func_rdy_reg;
	assign call_out    = call_reg;
	assign cmd_out     = cmd_reg;
	assign cmd_valid   = cmd_valid_reg;
	assign reply_valid = reply_vld_reg;
	assign reply_data  = reply_dat_reg;
	assign busy        = busy_reg;

endmodule : fpd_decoder

// [hdl/fpd_pkg.sv]
// Constants, opcode classes and carriers shared by the coprocessor opcode decoder.
package fpd_pkg;

	// ------------------------------------------------------------------
	// Opcode fields
	// ------------------------------------------------------------------
	localparam logic [3:0] FPD_HI_PICK_A      = 4'h0;
	localparam logic [3:0] FPD_HI_PICK_B      = 4'h1;
	localparam logic [3:0] FPD_HI_LOAD_A      = 4'h2;
	localparam logic [3:0] FPD_HI_LOAD_B      = 4'h3;
	localparam logic [3:0] FPD_HI_READBACK    = 4'h4;
	localparam logic [3:0] FPD_HI_COPY        = 4'h5;
	localparam logic [3:0] FPD_HI_FSUM        = 4'h6;
	localparam logic [3:0] FPD_HI_FDIFF       = 4'h7;
	localparam logic [3:0] FPD_HI_FPROD       = 4'h8;
	localparam logic [3:0] FPD_HI_FQUOT       = 4'h9;
	localparam logic [3:0] FPD_HI_ISUM        = 4'ha;
	localparam logic [3:0] FPD_HI_IDIFF       = 4'hb;
	localparam logic [3:0] FPD_HI_IPROD       = 4'hc;
	localparam logic [3:0] FPD_HI_IQUOT       = 4'hd;
	localparam logic [3:0] FPD_HI_UNARY       = 4'he;
	localparam logic [3:0] FPD_HI_MISC        = 4'hf;

	// Low nibbles of the Fx group
	localparam logic [3:0] FPD_LO_SYNC        = 4'h0;
	localparam logic [3:0] FPD_LO_TO_FLOAT    = 4'h1;
	localparam logic [3:0] FPD_LO_TO_LONG     = 4'h2;
	localparam logic [3:0] FPD_LO_FLOAT_COMPARE_OP    = 4'h3;
	localparam logic [3:0] FPD_LO_SBYTE       = 4'h4;
	localparam logic [3:0] FPD_LO_UBYTE       = 4'h5;
	localparam logic [3:0] FPD_LO_SWORD       = 4'h6;
	localparam logic [3:0] FPD_LO_UWORD       = 4'h7;
	localparam logic [3:0] FPD_LO_TEXT_FETCH  = 4'h8;
	localparam logic [3:0] FPD_LO_TEXT_REAL   = 4'h9;
	localparam logic [3:0] FPD_LO_REAL_TEXT   = 4'ha;
	localparam logic [3:0] FPD_LO_TEXT_INT    = 4'hb;
	localparam logic [3:0] FPD_LO_INT_TEXT    = 4'hc;
	localparam logic [3:0] FPD_LO_STATUS      = 4'hd;
	localparam logic [3:0] FPD_LO_PREFIX      = 4'he;
	localparam logic [3:0] FPD_LO_NOP         = 4'hf;

	// Unary function selectors carried in aux for the Ex group
	localparam logic [3:0] FPD_UF_FLOOR       = 4'h8;
	localparam logic [3:0] FPD_UF_CEIL        = 4'h9;
	localparam logic [3:0] FPD_UF_ROUND       = 4'ha;

	// Second byte after the prefix
	localparam logic [1:0] FPD_EXT_CALL_TOP   = 2'b00;
	localparam logic [7:0] FPD_EXT_COND_LO    = 8'h80;
	localparam logic [7:0] FPD_EXT_COND_HI    = 8'h84;
	localparam logic [7:0] FPD_EXT_TABLE      = 8'h88;
	localparam logic [7:0] FPD_EXT_POLY       = 8'h89;

	// ------------------------------------------------------------------
	// Counts, fixed values and reset values
	// ------------------------------------------------------------------
	localparam logic [2:0] FPD_ARGS_REAL      = 3'h4;
	localparam logic [2:0] FPD_ARGS_WORD      = 3'h2;
	localparam logic [2:0] FPD_ARGS_BYTE      = 3'h1;
	localparam logic [7:0] FPD_SYNC_BYTE      = 8'h5c;
	localparam logic [7:0] FPD_STR_END        = 8'h00;
	localparam logic [3:0] FPD_REG_ZERO       = 4'h0;
	localparam logic [3:0] FPD_PTR_RST        = 4'h0;

	// ------------------------------------------------------------------
	// Types
	// ------------------------------------------------------------------
	typedef enum logic [4:0] {
		FPD_OP_NOP, FPD_OP_WRITE_REG, FPD_OP_READ_REG, FPD_OP_COPY,
		FPD_OP_FSUM, FPD_OP_FDIFF, FPD_OP_FPROD, FPD_OP_FQUOT,
		FPD_OP_ISUM, FPD_OP_IDIFF, FPD_OP_IPROD, FPD_OP_IQUOT,
		FPD_OP_UNARY, FPD_OP_TO_FLOAT, FPD_OP_TO_LONG, FPD_OP_FLOAT_COMPARE_OP,
		FPD_OP_LOAD_INT, FPD_OP_TEXT_FETCH, FPD_OP_TEXT_CHAR, FPD_OP_TEXT_REAL,
		FPD_OP_TEXT_INT, FPD_OP_REAL_TEXT, FPD_OP_INT_TEXT, FPD_OP_STATUS,
		FPD_OP_COND, FPD_OP_EXT_OTHER
	} fpd_op_e;

	// Gray codes along idle -> prefix -> arg -> exec -> text -> skip
	typedef enum logic [2:0] {
		FPD_S_IDLE   = 3'b000,
		FPD_S_PREFIX = 3'b001,
		FPD_S_ARG    = 3'b011,
		FPD_S_EXEC   = 3'b010,
		FPD_S_TEXT   = 3'b110,
		FPD_S_SKIP   = 3'b111
	} fpd_state_e;

	typedef struct packed {
		logic       valid;
		logic [7:0] data;
		logic       last;
	} fpd_byte_s;

	typedef struct packed {
		fpd_op_e     op;
		logic [3:0]  a_ptr;
		logic [3:0]  b_ptr;
		logic [3:0]  idx;
		logic [7:0]  aux;
		logic [31:0] arg;
	} fpd_cmd_s;

	typedef struct packed {
		logic       valid;
		logic [5:0] num;
	} fpd_call_s;

endpackage : fpd_pkg
